// *** rtl/emp_pins_consts.svh ***
// Constants for the external memory port pin block
`ifndef EMP_PINS_CONSTS_SVH
`define EMP_PINS_CONSTS_SVH
`define EMP_ADDR_W 18
`define EMP_DATA_W 24
`define EMP_ADDR_RST 18'h0_0000
`define EMP_DATA_RST 24'h00_0000
`define EMP_OE_RST 1'h0
`define EMP_REL_RST 1'h1
`define EMP_CORE_CLOCK_OUTPUT_MAX_MHZ 100
`endif

// *** rtl/emp_pins_pkg.sv ***
// Types for the external memory port pin block
package emp_pins_pkg;
  typedef enum logic [1:0] {
    EMP_IDLE = 2'b00,
    EMP_READ = 2'b01,
    EMP_WRITE = 2'b10
  } emp_access_t;
endpackage : emp_pins_pkg

// *** rtl/emp_pins.sv ***
// External memory port address and data pin control
`include "emp_pins_consts.svh"

// Function
// - Stop or wait standby floats all port pins
// - Drive address only while owning bus
// - Hold address when no external access
// - Drive data only for owned writes
// - Weak keeper holds last data level
module emp_pins #(
  parameter int ADDR_W = `EMP_ADDR_W,
  parameter int DATA_W = `EMP_DATA_W
) (
  input wire logic clk, // Core clock
  input wire logic nrst, // Sync reset, active low
  input wire logic busOwned, // Bus mastership held
  input wire logic standby, // Stop or wait standby
  input wire logic accValid, // External access this cycle
  input wire logic accWrite, // Access is a write
  input wire logic [ADDR_W-1:0] accAddr, // Access address
  input wire logic [DATA_W-1:0] wrData, // Write data
  output logic [DATA_W-1:0] rdData, // Captured read data
  output logic busReleased, // Mastership given up
  output logic [ADDR_W-1:0] addrOut, // Address pins out
  output logic addrOe, // Address pins driven
  input wire logic [DATA_W-1:0] dataIn, // Data pins in
  output logic [DATA_W-1:0] dataOut, // Data pins out
  output logic dataOe // Data pins driven
);

  // ****************************************
  // Pin state
  // ****************************************
  // Address pins and their enable
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic addrOe_q;
  logic addrOe_d;
  // Data pins: one register serves drive and keeper
  logic dataOe_q;
  logic dataOe_d;
  logic [DATA_W-1:0] pin_q;
  logic [DATA_W-1:0] pin_d;
  // Read capture and release flag
  logic [DATA_W-1:0] rd_q;
  logic [DATA_W-1:0] rd_d;
  logic rel_q;
  logic rel_d;
  // Decoded control
  logic owner;
  logic [DATA_W-1:0] keepLevel;
  emp_pins_pkg::emp_access_t acc;

  // ****************************************
  // Helper functions
  // ****************************************
  // Sort a request into idle, read or write
  function automatic emp_pins_pkg::emp_access_t classify(
    input logic owned, // Bus held and awake
    input logic valid, // Request present
    input logic write // Request is a write
  );
    emp_pins_pkg::emp_access_t kind;
    if (!owned || !valid) begin
      kind = emp_pins_pkg::EMP_IDLE;
    end else if (write) begin
      kind = emp_pins_pkg::EMP_WRITE;
    end else begin
      kind = emp_pins_pkg::EMP_READ;
    end
    return kind;
  endfunction : classify

  // Level the keeper holds: own drive, else the lines
  function automatic logic [DATA_W-1:0] keeper(
    input logic driving, // Pins driven last cycle
    input logic [DATA_W-1:0] driven, // Value driven
    input logic [DATA_W-1:0] seen // Level on the lines
  );
    logic [DATA_W-1:0] level;
    if (driving) begin
      level = driven;
    end else begin
      level = seen;
    end
    return level;
  endfunction : keeper

  // ****************************************
  // Decode
  // ****************************************
  // Ownership is lost in standby
  assign owner = busOwned && !standby;

  // Classify the current access
  assign acc = classify(owner, accValid, accWrite);

  // Keeper holds its own drive, else the level the lines show
  assign keepLevel = keeper(dataOe_q, pin_q, dataIn);

  // ****************************************
  // Next state
  // ****************************************
  // Pin values for the next cycle; reset floats them
  always_comb begin
    addr_d = addr_q;
    addrOe_d = owner;
    dataOe_d = 1'h0;
    pin_d = keepLevel;
    rd_d = rd_q;
    rel_d = !owner;
    unique case (acc)
      emp_pins_pkg::EMP_IDLE: begin
        addr_d = addr_q;
      end
      emp_pins_pkg::EMP_READ: begin
        addr_d = accAddr;
        rd_d = dataIn;
      end
      emp_pins_pkg::EMP_WRITE: begin
        addr_d = accAddr;
        pin_d = wrData;
        dataOe_d = 1'h1;
      end
    endcase
    // Synchronous reset wins over any access
    if (!nrst) begin
      addr_d = `EMP_ADDR_RST;
      addrOe_d = `EMP_OE_RST;
      dataOe_d = `EMP_OE_RST;
      pin_d = `EMP_DATA_RST;
      rd_d = `EMP_DATA_RST;
      rel_d = `EMP_REL_RST;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Plain registers; reset is folded into the next values
  always_ff @(posedge clk) begin
    addr_q <= addr_d;
    addrOe_q <= addrOe_d;
    dataOe_q <= dataOe_d;
    pin_q <= pin_d;
    rd_q <= rd_d;
    rel_q <= rel_d;
  end

  // Outputs straight from the registers
  assign addrOut = addr_q;
  assign addrOe = addrOe_q;
  assign dataOut = pin_q;
  assign dataOe = dataOe_q;
  assign rdData = rd_q;
  assign busReleased = rel_q;

  // ****************************************
  // Checks
  // ****************************************
  // Standby request seen at an edge
  sequence s_standby;
    standby;
  endsequence

  // A read taken at an edge
  sequence s_read_taken;
    owner && accValid && !accWrite;
  endsequence

  // A write taken at an edge
  sequence s_write_taken;
    owner && accValid && accWrite;
  endsequence

  // Two steps: data driven, then let go
  sequence s_drive_end;
    dataOe ##1 !dataOe;
  endsequence

  // Standby drops every driver and flags release
  a_standby_float: assert property (@(posedge clk)
    disable iff (!nrst)
    s_standby |=> !addrOe && !dataOe && busReleased)
    else $error("pins driven after standby");

  // No address drive without mastership
  a_addr_owner: assert property (@(posedge clk)
    disable iff (!nrst)
    !busOwned |=> !addrOe)
    else $error("address driven without ownership");

  // Awake owner drives address and clears release
  a_owner_drive: assert property (@(posedge clk)
    disable iff (!nrst)
    owner |=> addrOe && !busReleased)
    else $error("owner not driving address");

  // Idle cycles leave the address alone
  a_addr_hold: assert property (@(posedge clk)
    disable iff (!nrst)
    !accValid && $past(nrst) |=> $stable(addrOut))
    else $error("address moved while idle");

  // Taken access puts its address on the pins
  a_addr_load: assert property (@(posedge clk)
    disable iff (!nrst)
    owner && accValid |=> addrOut == $past(accAddr))
    else $error("address not loaded");

  // A taken write drives its data for one cycle
  a_data_write: assert property (@(posedge clk)
    disable iff (!nrst)
    s_write_taken |=> dataOe && dataOut == $past(wrData))
    else $error("write data not driven");

  // Anything but a taken write leaves data floating
  a_data_float: assert property (@(posedge clk)
    disable iff (!nrst)
    !(owner && accValid && accWrite) |=> !dataOe)
    else $error("data driven without write");

  // A taken read captures the lines
  a_read_capture: assert property (@(posedge clk)
    disable iff (!nrst)
    s_read_taken |=> rdData == $past(dataIn) && !dataOe)
    else $error("read data not captured");

  // Floating lines are followed by the keeper
  a_keeper_track: assert property (@(posedge clk)
    disable iff (!nrst)
    !dataOe && !(owner && accValid && accWrite)
    |=> dataOut == $past(dataIn))
    else $error("keeper lost the line level");

  // Level driven last stays after release
  a_keeper_hold: assert property (@(posedge clk)
    disable iff (!nrst)
    s_drive_end |-> dataOut == $past(dataOut))
    else $error("keeper lost level");

  // Reset floats address and data
  a_reset_float: assert property (@(posedge clk)
    !nrst |=> !addrOe && !dataOe)
    else $error("pins driven in reset");

endmodule : emp_pins

// *** testbench/emp_mem_model.sv ***
// Memory model that answers reads on the data pins
module emp_mem_model (
  input wire logic rdReq, // Read cycle in progress
  input wire logic [17:0] addr, // Read address
  output logic drive, // Memory drives data pins
  output logic [23:0] data // Data it drives
);
  // Drive only on reads; released pins show a pattern
  assign drive = rdReq;
  assign data = rdReq ? {6'h00, addr} ^ 24'hA5_A5A5 : 24'h5A_5A5A;
endmodule : emp_mem_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the external memory port pins
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, busOwned = 0, standby = 0;
  logic accValid = 0, accWrite = 0, addrOe, dataOe, busReleased, memDrive;
  logic [17:0] accAddr = 0, addrOut;
  logic [23:0] wrData = 0, rdData, dataOut, dataIn, memData;
  int badCount = 0;
  int numChecks = 0;
  // Wire level: device, then memory, else keeper
  assign dataIn = dataOe ? dataOut : memDrive ? memData : dataOut;
  emp_pins DUT (.clk(clk), .nrst(nrst), .busOwned(busOwned),
    .standby(standby), .accValid(accValid), .accWrite(accWrite),
    .accAddr(accAddr), .wrData(wrData), .rdData(rdData),
    .busReleased(busReleased), .addrOut(addrOut), .addrOe(addrOe),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));
  emp_mem_model mem (.rdReq(accValid & ~accWrite & busOwned & ~standby),
    .addr(accAddr), .drive(memDrive), .data(memData));
  // Clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    numChecks++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic testDone();
    $display("checks %0d errors %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : testDone
  // One access, returns at the falling edge after it is taken
  task automatic acc(input logic w, input logic [17:0] a,
      input logic [23:0] d);
    @(negedge clk);
    {accValid, accWrite, accAddr, wrData} = {1'h1, w, a, d};
    @(negedge clk);
    accValid = 1'h0;
  endtask : acc
  // Reset at start: pins float, then the owner drives
  task automatic t_reset();
    repeat (6) @(negedge clk);
    chk(24'({addrOe, dataOe, busReleased}), 24'h00_0001);
    chk(24'(addrOut), 24'h00_0000);
    nrst = 1'h1;
    busOwned = 1'h1;
    repeat (2) @(negedge clk);
    chk(24'({addrOe, dataOe, busReleased}), 24'h00_0004);
  endtask : t_reset
  task automatic t_write();
    acc(1'h1, 18'h3_FFFF, 24'hC3_0F0F);
    chk(24'(addrOut), 24'h03_FFFF);
    chk(24'(dataOe), 24'h00_0001);
    chk(dataOut, 24'hC3_0F0F);
    @(negedge clk);
    chk(24'(dataOe), 24'h00_0000);
    chk(dataOut, 24'hC3_0F0F);
    chk(24'(addrOe), 24'h00_0001);
  endtask : t_write
  task automatic t_read();
    acc(1'h0, 18'h0_0001, 24'h00_0000);
    chk(rdData, 24'hA5_A5A4);
    chk(24'(dataOe), 24'h00_0000);
    // Move the request address while idle: pins must not follow
    accAddr = 18'h2_AAAA;
    repeat (3) @(negedge clk);
    chk(24'(addrOut), 24'h00_0001);
    chk(dataOut, 24'hA5_A5A4);
  endtask : t_read
  task automatic t_standby();
    standby = 1'h1;
    acc(1'h1, 18'h0_0002, 24'h00_0000);
    chk(24'({addrOe, dataOe, busReleased}), 24'h00_0001);
    chk(24'(addrOut), 24'h00_0001);
    chk(dataOut, 24'hA5_A5A4);
    {standby, busOwned} = 2'h0;
    repeat (2) @(negedge clk);
    chk(24'({addrOe, dataOe, busReleased}), 24'h00_0001);
  endtask : t_standby
  // Reset in mid-run while owned, then a write right after
  task automatic t_reset_mid();
    busOwned = 1'h1;
    repeat (2) @(negedge clk);
    chk(24'({addrOe, dataOe, busReleased}), 24'h00_0004);
    nrst = 1'h0;
    repeat (2) @(negedge clk);
    chk(24'({addrOe, dataOe, busReleased}), 24'h00_0001);
    chk(24'(addrOut), 24'h00_0000);
    chk(dataOut, 24'h00_0000);
    nrst = 1'h1;
    @(negedge clk);
    chk(24'({addrOe, dataOe, busReleased}), 24'h00_0004);
    acc(1'h1, 18'h1_2345, 24'h0F_F0F0);
    chk(24'(addrOut), 24'h01_2345);
    chk(dataOut, 24'h0F_F0F0);
  endtask : t_reset_mid
  // Watchdog: about fifteen times the expected run
  initial begin
    #2000;
    badCount++;
    testDone();
  end
  // Main sequence
  initial begin
    t_reset();
    t_write();
    t_read();
    t_standby();
    t_reset_mid();
    testDone();
  end
endmodule : tb_top
